/* File: rtl/smc_host.sv */
// sram host controller driving a 64k x 16 async sram with byte lanes
`timescale 1ns/1ps
`default_nettype none
module smc_host
  import smc_pkg::*;
(
  input  wire logic              clock,        // system clock, 25 MHz
  input  wire logic              rst_n,        // async reset, active low
  input  wire logic              req_valid,    // request offered
  output logic                   req_ready,    // request taken this cycle
  input  wire smc_req_t          req,          // request contents
  output logic                   done,         // access finished pulse
  output logic      [DATA_W-1:0] rdata,        // read data
  output smc_pins_t              pins,         // sram control and address
  input  wire logic [DATA_W-1:0] data_in,      // shared_data_lines input
  output logic      [DATA_W-1:0] data_out,     // shared_data_lines output
  output logic      [DATA_W-1:0] data_oe       // per-bit output enable
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    smc_state_t        st;
    logic [CNT_W-1:0]  cnt;
    smc_pins_t         pins;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lanes;
    logic              done;
  } smc_host_st_t;

  localparam smc_pins_t PINS_IDLE = '{word_addr: '0, chip_sel_n: 1'b1,
    write_en_n: 1'b1, out_en_n: 1'b1, low_lane_en_n: 1'b1,
    high_lane_en_n: 1'b1};

  smc_host_st_t cur;
  smc_host_st_t next_cur;
  logic [1:0]   drive;
  logic [1:0]   capture;
  logic [1:0]   lane_oe;

  assign req_ready = (cur.st == ST_IDLE);

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    case (cur.st)
      ST_IDLE:
      begin
        next_cur.pins = PINS_IDLE;
        next_cur.pins.word_addr = cur.pins.word_addr;
        // an empty lane mask means no access at all, finish at once
        if (req_valid && req.lanes == LANES_NONE)
        begin
          next_cur.done = 1'b1;
        end
        else if (req_valid && req.op == SMC_READ)
        begin
          // address, select and enables move together: valid at the fall
          next_cur.pins.word_addr      = req.addr;
          next_cur.pins.chip_sel_n     = 1'b0;
          next_cur.pins.out_en_n       = 1'b0;
          next_cur.pins.write_en_n     = 1'b1;
          next_cur.pins.low_lane_en_n  = ~req.lanes[0];
          next_cur.pins.high_lane_en_n = ~req.lanes[1];
          next_cur.lanes = req.lanes;
          next_cur.cnt   = READ_WAIT;
          next_cur.st    = ST_RD_WAIT;
        end
        else if (req_valid)
        begin
          // write enable falls before select, so outputs never turn on
          next_cur.pins.word_addr      = req.addr;
          next_cur.pins.write_en_n     = 1'b0;
          next_cur.pins.low_lane_en_n  = ~req.lanes[0];
          next_cur.pins.high_lane_en_n = ~req.lanes[1];
          next_cur.wdata = req.wdata;
          next_cur.lanes = req.lanes;
          next_cur.cnt   = SETUP_WAIT;
          next_cur.st    = ST_WR_SETUP;
        end
      end
      ST_RD_WAIT:
      begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE)
        begin
          next_cur.st = ST_RD_DONE;
        end
      end
      ST_RD_DONE:
      begin
        next_cur.pins.chip_sel_n = 1'b1;
        next_cur.pins.out_en_n   = 1'b1;
        next_cur.done = 1'b1;
        next_cur.st   = ST_IDLE;
      end
      ST_WR_SETUP:
      begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE)
        begin
          next_cur.pins.chip_sel_n = 1'b0;
          next_cur.cnt = READ_WAIT;
          next_cur.st  = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE:
      begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE)
        begin
          // end the write by select rising; address held past it
          next_cur.pins.chip_sel_n = 1'b1;
          next_cur.cnt = RECOV_WAIT;
          next_cur.st  = ST_WR_RECOV;
        end
      end
      ST_WR_RECOV:
      begin
        next_cur.pins.write_en_n = 1'b1;
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE)
        begin
          next_cur.done = 1'b1;
          next_cur.st   = ST_IDLE;
        end
      end
      default:
      begin
        next_cur = '0;
        next_cur.pins = PINS_IDLE;
        next_cur.st   = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur      <= '0;
      cur.pins <= PINS_IDLE;
      cur.st   <= ST_IDLE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------------
  // data lanes
  // ------------------------------------------------------------------
  // drive only once select is low in a write; never while reading
  always_comb
  begin
    drive   = LANES_NONE;
    capture = LANES_NONE;
    if (next_cur.st == ST_WR_PULSE)
    begin
      drive = cur.lanes;
    end
    if (cur.st == ST_RD_WAIT && cur.cnt == CNT_ONE)
    begin
      capture = cur.lanes;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    smc_lane_drv u_lane (
      .clock   (clock),
      .rst_n   (rst_n),
      .drive   (drive[g]),
      .capture (capture[g]),
      .wdata   (cur.wdata[g*LANE_W +: LANE_W]),
      .pin_in  (data_in[g*LANE_W +: LANE_W]),
      .pin_out (data_out[g*LANE_W +: LANE_W]),
      .pin_oe  (lane_oe[g]),
      .rdata   (rdata[g*LANE_W +: LANE_W])
    );
    assign data_oe[g*LANE_W +: LANE_W] = {LANE_W{lane_oe[g]}};
  end

  assign pins = cur.pins;
  assign done = cur.done;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_no_drive_read;
    @(posedge clock) disable iff (!rst_n)
      !pins.out_en_n |-> (data_oe == '0);
  endproperty
  a_no_drive_read: assert property (p_no_drive_read)
    else $error("data driven while sram output enabled");

  property p_we_high_read;
    @(posedge clock) disable iff (!rst_n)
      !pins.out_en_n |-> pins.write_en_n;
  endproperty
  a_we_high_read: assert property (p_we_high_read)
    else $error("write enable low during read");

  property p_cs_after_we;
    @(posedge clock) disable iff (!rst_n)
      $fell(pins.chip_sel_n) && !pins.write_en_n |->
        !$past(pins.write_en_n);
  endproperty
  a_cs_after_we: assert property (p_cs_after_we)
    else $error("select fell before write enable");

  property p_addr_stable_wr;
    @(posedge clock) disable iff (!rst_n)
      !pins.write_en_n && !$past(pins.write_en_n) |->
        $stable(pins.word_addr);
  endproperty
  a_addr_stable_wr: assert property (p_addr_stable_wr)
    else $error("address moved during write");

  property p_addr_at_cs;
    @(posedge clock) disable iff (!rst_n)
      !pins.chip_sel_n && !$past(pins.chip_sel_n) |->
        $stable(pins.word_addr);
  endproperty
  a_addr_at_cs: assert property (p_addr_at_cs)
    else $error("address moved while selected");

  property p_lane_gate;
    @(posedge clock) disable iff (!rst_n)
      (data_oe[0] |-> !pins.low_lane_en_n) and
      (data_oe[DATA_W-1] |-> !pins.high_lane_en_n);
  endproperty
  a_lane_gate: assert property (p_lane_gate)
    else $error("lane driven without its enable");

  property p_write_len;
    @(posedge clock) disable iff (!rst_n)
      $fell(pins.chip_sel_n) && !pins.write_en_n |->
        !pins.chip_sel_n [*1] ##1 pins.chip_sel_n ##1 pins.write_en_n;
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("write interval wrong length");

  property p_read_done;
    @(posedge clock) disable iff (!rst_n)
      $fell(pins.out_en_n) |-> ##2 done;
  endproperty
  a_read_done: assert property (p_read_done)
    else $error("read did not finish in time");

  property p_empty_req;
    @(posedge clock) disable iff (!rst_n)
      req_valid && req_ready && req.lanes == LANES_NONE |->
        ##1 done && pins.chip_sel_n;
  endproperty
  a_empty_req: assert property (p_empty_req)
    else $error("empty lane request caused access");

  c_read: cover property (@(posedge clock) disable iff (!rst_n)
    req_valid && req_ready && req.op == SMC_READ ##3 done);
  c_write: cover property (@(posedge clock) disable iff (!rst_n)
    req_valid && req_ready && req.op == SMC_WRITE ##4 done);
  c_half: cover property (@(posedge clock) disable iff (!rst_n)
    !pins.out_en_n && pins.high_lane_en_n && !pins.low_lane_en_n);
endmodule : smc_host
`default_nettype wire

/* File: rtl/smc_lane_drv.sv */
// one byte lane of the shared data lines: drive and capture
`timescale 1ns/1ps
`default_nettype none
module smc_lane_drv
  import smc_pkg::*;
(
  input  wire logic              clock,     // system clock
  input  wire logic              rst_n,     // async reset, active low
  input  wire logic              drive,     // enable lane output
  input  wire logic              capture,   // latch lane input
  input  wire logic [LANE_W-1:0] wdata,     // write byte
  input  wire logic [LANE_W-1:0] pin_in,    // lane pins, input side
  output logic      [LANE_W-1:0] pin_out,   // lane pins, output side
  output logic                   pin_oe,    // lane output enable
  output logic      [LANE_W-1:0] rdata      // captured byte
);
  typedef struct packed {
    logic [LANE_W-1:0] out;
    logic              oe;
    logic [LANE_W-1:0] rd;
  } smc_lane_st_t;

  smc_lane_st_t cur;
  smc_lane_st_t next_cur;

  always_comb
  begin
    next_cur     = cur;
    next_cur.oe  = drive;
    next_cur.out = drive ? wdata : cur.out;
    if (capture)
    begin
      next_cur.rd = pin_in;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign pin_out = cur.out;
  assign pin_oe  = cur.oe;
  assign rdata   = cur.rd;
endmodule : smc_lane_drv
`default_nettype wire

/* File: shared/smc_pkg.sv */
// package for the sram host controller: pin bundles, commands, timing
package smc_pkg;

  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned LANE_W     = 8;
  localparam int unsigned WORD_COUNT = 65536;

  // clock and access timing
  localparam int unsigned CLK_PERIOD_NS        = 40;
  localparam int unsigned ACCESS_TIME_NS       = 12;
  localparam int unsigned addr_setup_time      = 0;
  localparam int unsigned write_recovery_time  = 0;
  localparam int unsigned ACCESS_CYC =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC_RAW =
    (addr_setup_time + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
  localparam int unsigned RECOV_CYC_RAW =
    (write_recovery_time + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOV_CYC = (RECOV_CYC_RAW < 1) ? 1 : RECOV_CYC_RAW;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] READ_WAIT  = CNT_W'(ACCESS_CYC);
  localparam logic [CNT_W-1:0] SETUP_WAIT = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] RECOV_WAIT = CNT_W'(RECOV_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;

  localparam logic [1:0] LANES_NONE = 2'h0;
  localparam logic [1:0] LANES_ALL  = 2'h3;

  typedef enum logic { SMC_READ, SMC_WRITE } smc_op_t;

  typedef struct packed {
    smc_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lanes;   // bit 0 low lane, bit 1 high lane
  } smc_req_t;

  // controller-driven sram pins (all active low except address and data)
  typedef struct packed {
    logic [ADDR_W-1:0] word_addr;
    logic              chip_sel_n;
    logic              write_en_n;
    logic              out_en_n;
    logic              low_lane_en_n;
    logic              high_lane_en_n;
  } smc_pins_t;

  typedef enum {
    ST_IDLE, ST_RD_WAIT, ST_RD_DONE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_RECOV
  } smc_state_t;

endpackage : smc_pkg

/* File: testbench/smc_sram_model.sv */
// behavioural model of the 64k x 16 static memory on the far side
`timescale 1ns/1ps
`default_nettype none
module smc_sram_model
  import smc_pkg::*;
(
  input  wire smc_pins_t         pins,     // control and address from host
  input  wire logic [DATA_W-1:0] data_in,  // resolved shared data lines
  output logic      [DATA_W-1:0] mem_out,  // read data toward the lines
  output logic      [DATA_W-1:0] mem_oe    // per-bit drive enable
);
  // ----------------------------------------------------------------
  // storage, read drive and write capture
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [WORD_COUNT];
  logic              rd;
  logic              wr;
  logic [DATA_W-1:0] data_late;
  // the host lets go of the lines in the same step that ends the write;
  // a short lag keeps the closing value instead of the released lines
  assign #1 data_late = data_in;
  // power-up contents are arbitrary; a fixed pattern keeps reads checkable
  initial
    for (int i = 0; i < WORD_COUNT; i++)
      mem[i] = 16'(i) ^ 16'h5a3c;
  assign rd = !pins.chip_sel_n && pins.write_en_n && !pins.out_en_n;
  assign wr = !pins.chip_sel_n && !pins.write_en_n;
  assign mem_out = mem[pins.word_addr];
  assign mem_oe = {{LANE_W{rd && !pins.high_lane_en_n}},
                   {LANE_W{rd && !pins.low_lane_en_n}}};
  // level write: the last value seen before the interval closes stays
  always @*
    if (wr)
    begin
      if (!pins.low_lane_en_n)
        mem[pins.word_addr][7:0] = data_late[7:0];
      if (!pins.high_lane_en_n)
        mem[pins.word_addr][15:8] = data_late[15:8];
    end
endmodule : smc_sram_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the sram host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smc_pkg::*;
  logic clock, rst_n, req_valid, req_ready, done;
  smc_req_t req;
  smc_pins_t pins;
  logic [DATA_W-1:0] rdata, data_in, data_out, data_oe, mem_out, mem_oe;
  logic [DATA_W-1:0] exp_rdata, cur_addr, cur_wdata;
  logic [DATA_W-1:0] float_pat = 16'ha5a5;
  logic [1:0] cur_lanes;
  logic [DATA_W-1:0] ref_mem [int];
  int miscompares, checks_done, cycles;
  realtime dropped_at;

  smc_host smc_host_inst (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done),
    .rdata(rdata), .pins(pins), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));
  smc_sram_model smc_sram_model_inst (.pins(pins), .data_in(data_in),
    .mem_out(mem_out), .mem_oe(mem_oe));

  // released lines show a toggling pattern, never the last driven value
  assign data_in = (data_oe & data_out) | (mem_oe & mem_out)
                 | (~data_oe & ~mem_oe & float_pat);

  initial
  begin
    clock = 0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
  begin
    float_pat <= ~float_pat;
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input logic [33:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  function automatic logic [15:0] ref_rd(input logic [15:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : (a ^ 16'h5a3c);
  endfunction : ref_rd

  // ----------------------------------------------------------------
  // pin monitor, sampled at the falling edge
  // ----------------------------------------------------------------
  always @(negedge clock)
    if (rst_n)
    begin
      check(34'(data_oe & mem_oe), 34'h0, "contention");
      if (!pins.out_en_n)
        check(34'(pins.write_en_n), 34'h1, "we in read");
      if (!pins.chip_sel_n)
      begin
        check(34'(pins.word_addr), 34'(cur_addr), "addr");
        check(34'(cur_lanes != 2'h0), 34'h1, "empty access");
      end
      if (!pins.chip_sel_n && !pins.write_en_n)
      begin
        check(34'(data_oe), 34'({{8{cur_lanes[1]}}, {8{cur_lanes[0]}}}),
              "write lanes");
        check(34'(data_out & data_oe),
              34'(cur_wdata & {{8{cur_lanes[1]}}, {8{cur_lanes[0]}}}),
              "write data");
      end
      else
        check(34'(data_oe), 34'h0, "drive outside write");
    end

  task automatic do_op(input smc_op_t op, input logic [15:0] a, d,
                       input logic [1:0] ln);
    int n;
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    if (dropped_at == $realtime)
      @(negedge clock);
    cur_addr = a;
    cur_wdata = d;
    cur_lanes = ln;
    req = '{op, a, d, ln};
    req_valid = 1;
    while (req_ready !== 1'b1)
      @(negedge clock);
    @(posedge clock);
    @(negedge clock);
    req_valid = 0;
    dropped_at = $realtime;
    n = 1;
    while (done !== 1'b1 && n < 10)
    begin
      @(negedge clock);
      n++;
    end
    check(34'(n), (ln == 0) ? 34'h1 : (op == SMC_WRITE) ? 34'h4 : 34'h3,
          "latency");
    if (op == SMC_WRITE && ln != 0)
      ref_mem[a] = (ref_rd(a) & ~m) | (d & m);
    if (op == SMC_READ)
    begin
      exp_rdata = (exp_rdata & ~m) | (ref_rd(a) & m);
      check(34'(rdata), 34'(exp_rdata), "read data");
    end
  endtask : do_op

  initial
  begin
    void'($urandom(85));
    rst_n = 0;
    req_valid = 0;
    req = '0;
    exp_rdata = 16'h0000;
    dropped_at = -1.0;
    repeat (6) @(negedge clock);
    check(34'(pins), 34'h1f, "reset pins");
    check(34'({data_oe, done, rdata}), 34'h0, "reset outputs");
    check(34'(req_ready), 34'h1, "reset ready");
    rst_n = 1;
    $display("test reset done");
    do_op(SMC_WRITE, 16'h0000, 16'h1234, LANES_ALL);
    do_op(SMC_WRITE, 16'hffff, 16'hbeef, 2'h1);
    do_op(SMC_WRITE, 16'hffff, 16'hcafe, 2'h2);
    do_op(SMC_READ, 16'hffff, 16'h0000, 2'h1);
    do_op(SMC_READ, 16'h0000, 16'h0000, 2'h2);
    do_op(SMC_READ, 16'hffff, 16'h0000, LANES_ALL);
    do_op(SMC_WRITE, 16'h0000, 16'hdead, LANES_NONE);
    do_op(SMC_READ, 16'h0000, 16'h0000, LANES_NONE);
    do_op(SMC_READ, 16'h0000, 16'h0000, LANES_ALL);
    $display("test directed done");
    repeat (300)
      do_op(smc_op_t'($urandom_range(1)),
            ($urandom_range(3) == 0) ? 16'hffff : 16'($urandom_range(7)),
            16'($urandom), 2'($urandom_range(3)));
    $display("test random done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
